/* File: rtl/trsf_pkg.sv */
// Functional notes
// - Bit 4 of the CPU thermal configuration register at 0x36 turns the legacy swap mode on while set and off while clear.
// - In swap mode register 0x25 shows CPU channel 0 data and register 0x33 shows the first remote diode reading.
// - In swap mode the remote-one registers carry relative CPU format and the CPU channel 0 registers carry absolute format.
// - In swap mode the pairs 0x4E/0x34, 0x4F/0x35, 0x67/0x3B and 0x6A/0x3D exchange their channel.
// - In swap mode bits 7:4 of 0x5F exchange their channel with bits 7:4 of 0x3C.
// - In swap mode bits 3:0 of 0x62 exchange their channel with bits 3:0 of 0x3C.
// - In swap mode bits 7:4 of 0x6D exchange their channel with bits 3:0 of 0x6E.
// - In swap mode bits 3:0 of 0x6D and bits 7:4 of 0x6E are exchanged as well.
// - In swap mode the pairs 0x70/0x94 and 0x8B/0x8A exchange their channel.
// - In swap mode a PWM zone field of 000 in 0x5C, 0x5D or 0x5E selects CPU channel 0; other values stay.
// - The upper 8 bits of each 10-bit local result are stored in the read-only register 0x26.
// - The two low bits of each 10-bit result, quarter degree steps, are stored in register 0x77.
// - In twos-complement form the upper byte is the signed temperature and a diode fault reads 1000 0000 00.
// - In biased form the upper byte is the temperature plus 64 and a diode fault reads all zero.
// - Codes span -63 to +127 degrees, or up to +191 degrees when the extended range uses the biased form.
package trsf_pkg;
    localparam int ADR_W = 10;
    localparam int DAT_W = 32;
    localparam int NUM_RW = 21;
    localparam int NUM_CH = 2;
    localparam int CH_LOCAL = 0;
    localparam int CH_REM1 = 1;

    localparam logic [7:0] IDX_REM1_READ = 8'h25;
    localparam logic [7:0] IDX_LOCAL_READ = 8'h26;
    localparam logic [7:0] IDX_CPU0_READ = 8'h33;
    localparam logic [7:0] IDX_CPU0_LOW = 8'h34;
    localparam logic [7:0] IDX_CPU0_HIGH = 8'h35;
    localparam logic [7:0] IDX_CPU_CFG = 8'h36;
    localparam logic [7:0] IDX_CPU0_FANST = 8'h3b;
    localparam logic [7:0] IDX_CPU0_SPAN = 8'h3c;
    localparam logic [7:0] IDX_CPU0_OVT = 8'h3d;
    localparam logic [7:0] IDX_REM1_LOW = 8'h4e;
    localparam logic [7:0] IDX_REM1_HIGH = 8'h4f;
    localparam logic [7:0] IDX_PWM1_ZONE = 8'h5c;
    localparam logic [7:0] IDX_PWM2_ZONE = 8'h5d;
    localparam logic [7:0] IDX_PWM3_ZONE = 8'h5e;
    localparam logic [7:0] IDX_REM1_SPAN = 8'h5f;
    localparam logic [7:0] IDX_REM_ACOUS = 8'h62;
    localparam logic [7:0] IDX_REM1_FANST = 8'h67;
    localparam logic [7:0] IDX_REM1_OVT = 8'h6a;
    localparam logic [7:0] IDX_HYST_A = 8'h6d;
    localparam logic [7:0] IDX_HYST_B = 8'h6e;
    localparam logic [7:0] IDX_REM1_TRIM = 8'h70;
    localparam logic [7:0] IDX_EXT_RES = 8'h77;
    localparam logic [7:0] IDX_CPU0_OPPT = 8'h8a;
    localparam logic [7:0] IDX_REM1_OPPT = 8'h8b;
    localparam logic [7:0] IDX_CPU0_TRIM = 8'h94;
    localparam logic [7:0] IDX_FMT_CFG = 8'hf0;

    // Storage slots of the writable registers, in default-owner layout
    localparam logic [7:0] RW_IDX [NUM_RW] = '{
        IDX_CPU0_LOW, IDX_CPU0_HIGH, IDX_CPU_CFG, IDX_CPU0_FANST,
        IDX_CPU0_SPAN, IDX_CPU0_OVT, IDX_REM1_LOW, IDX_REM1_HIGH,
        IDX_PWM1_ZONE, IDX_PWM2_ZONE, IDX_PWM3_ZONE, IDX_REM1_SPAN,
        IDX_REM_ACOUS, IDX_REM1_FANST, IDX_REM1_OVT, IDX_HYST_A,
        IDX_HYST_B, IDX_REM1_TRIM, IDX_CPU0_OPPT, IDX_REM1_OPPT,
        IDX_CPU0_TRIM};

    localparam int SWAP_BIT = 4;
    localparam int ZONE_MSB = 7;
    localparam int ZONE_LSB = 5;
    localparam logic [2:0] ZONE_REM1 = 3'h0;
    localparam logic [2:0] ZONE_CPU0 = 3'h7;
    localparam int FMT_BIASED_BIT = 0;
    localparam int FMT_EXT_BIT = 1;
    localparam int EXT_LOCAL_LSB = 2;
    localparam int EXT_REM1_LSB = 0;

    localparam logic [7:0] RW_RESET = 8'h00;
    localparam logic [7:0] FMT_RESET = 8'h00;
    localparam logic [7:0] READ_RESET = 8'h00;

    localparam int FRAC_BITS = 2;
    localparam int TEMP_MIN_DEG = -63;
    localparam int TEMP_MAX_DEG = 127;
    localparam int TEMP_MAX_EXT_DEG = 191;
    localparam int BIAS_DEG = 64;
    localparam logic [7:0] FAULT_TWOS = 8'h80;
    localparam logic [7:0] FAULT_BIAS = 8'h00;
endpackage

/* File: rtl/trsf_enc_if.sv */
`timescale 1ns/1ps
interface trsf_enc_if;
    logic signed [10:0] raw;
    logic fault;
    logic biased;
    logic ext;
    logic [9:0] code;
    modport enc (input raw, input fault, input biased, input ext,
        output code);
    modport user (output raw, output fault, output biased, output ext,
        input code);
endinterface

/* File: rtl/trsf_encoder.sv */
`timescale 1ns/1ps
module trsf_encoder
(
    trsf_enc_if.enc e
);
    import trsf_pkg::*;

    localparam logic signed [10:0] Q_MIN = 11'(TEMP_MIN_DEG * 4);
    localparam logic signed [10:0] Q_MAX = 11'(TEMP_MAX_DEG * 4 + 3);
    localparam logic signed [10:0] Q_MAX_EXT =
        11'(TEMP_MAX_EXT_DEG * 4 + 3);
    localparam logic signed [10:0] Q_BIAS = 11'(BIAS_DEG * 4);

    logic signed [10:0] hi_lim;
    logic signed [10:0] clamped;
    logic signed [10:0] biased_q;

    // Extended span only exists in the biased code; twos stops at 127
    assign hi_lim = (e.biased && e.ext) ? Q_MAX_EXT : Q_MAX;

    always_comb
    begin
        if (e.raw < Q_MIN)
            clamped = Q_MIN;
        else if (e.raw > hi_lim)
            clamped = hi_lim;
        else
            clamped = e.raw;
    end

    assign biased_q = clamped + Q_BIAS;

    always_comb
    begin
        if (e.fault)
            e.code = e.biased ? {FAULT_BIAS, 2'b00}
                              : {FAULT_TWOS, 2'b00};
        else if (e.biased)
            e.code = biased_q[9:0];
        else
            e.code = clamped[9:0];
    end
endmodule // trsf_encoder

/* File: rtl/trsf_regs.sv */
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
module trsf_regs
#(
    parameter int WB_ADR_W = trsf_pkg::ADR_W
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [WB_ADR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [trsf_pkg::DAT_W-1:0] i_wb_dat,
    output logic [trsf_pkg::DAT_W-1:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_local_valid,
    input wire logic signed [10:0] i_local_raw,
    input wire logic i_local_fault,
    input wire logic i_rem1_valid,
    input wire logic signed [10:0] i_rem1_raw,
    input wire logic i_rem1_fault,
    input wire logic i_cpu0_valid,
    input wire logic [7:0] i_cpu0_value,
    output logic o_swap_mode,
    output logic o_fmt_biased,
    output logic o_fmt_ext,
    output logic [8:0] o_pwm_zone_eff,
    output logic [trsf_pkg::NUM_RW*8-1:0] o_settings
);
    import trsf_pkg::*;

    if (WB_ADR_W < 10)
        $error("trsf_regs: address bus must hold ten bits");

    typedef logic [5:0] trsf_nib_type;

    logic [3:0] nib_r [2*NUM_RW];
    logic [7:0] fmt_r;
    logic [7:0] local_r;
    logic [7:0] rem1_r;
    logic [7:0] cpu0_r;
    logic [7:0] ext_r;
    logic ack_r;
    logic [DAT_W-1:0] rdat_r;
    logic [7:0] rdat_nxt;

    logic [7:0] idx;
    logic req_go;
    logic wr_go;
    logic rd_go;
    logic swap;
    logic biased;
    logic [8:0] hi_view;
    logic [8:0] lo_view;
    logic [5:0] hi_look;
    logic [5:0] lo_look;
    trsf_nib_type hi_nib;
    trsf_nib_type lo_nib;

    logic [9:0] code [NUM_CH];
    logic signed [10:0] ch_raw [NUM_CH];
    logic ch_fault [NUM_CH];

    // Map a nibble seen on the bus to the nibble that holds it.
    // Storage keeps each channel's value in its default-owner place,
    // so o_settings never shows the swap; only o_pwm_zone_eff follows it.
    function automatic logic [8:0] view_to_phys(
        input logic [7:0] a,
        input logic hi,
        input logic sw
    );
        logic [8:0] r;
        r = {a, hi};
        if (sw)
        begin
            case (a)
                IDX_CPU0_LOW: r = {IDX_REM1_LOW, hi};
                IDX_REM1_LOW: r = {IDX_CPU0_LOW, hi};
                IDX_CPU0_HIGH: r = {IDX_REM1_HIGH, hi};
                IDX_REM1_HIGH: r = {IDX_CPU0_HIGH, hi};
                IDX_CPU0_FANST: r = {IDX_REM1_FANST, hi};
                IDX_REM1_FANST: r = {IDX_CPU0_FANST, hi};
                IDX_CPU0_OVT: r = {IDX_REM1_OVT, hi};
                IDX_REM1_OVT: r = {IDX_CPU0_OVT, hi};
                IDX_REM1_TRIM: r = {IDX_CPU0_TRIM, hi};
                IDX_CPU0_TRIM: r = {IDX_REM1_TRIM, hi};
                IDX_REM1_OPPT: r = {IDX_CPU0_OPPT, hi};
                IDX_CPU0_OPPT: r = {IDX_REM1_OPPT, hi};
                IDX_CPU0_SPAN:
                    r = hi ? {IDX_REM1_SPAN, 1'b1}
                           : {IDX_REM_ACOUS, 1'b0};
                IDX_REM1_SPAN:
                    r = hi ? {IDX_CPU0_SPAN, 1'b1} : {a, 1'b0};
                IDX_REM_ACOUS:
                    r = hi ? {a, 1'b1} : {IDX_CPU0_SPAN, 1'b0};
                IDX_HYST_A: r = {IDX_HYST_B, ~hi};
                IDX_HYST_B: r = {IDX_HYST_A, ~hi};
                default: r = {a, hi};
            endcase
        end
        return r;
    endfunction

    // Returns {hit, slot}
    function automatic logic [5:0] slot_lookup(input logic [7:0] a);
        logic [5:0] r;
        r = 6'h00;
        for (int s = 0; s < NUM_RW; s++)
        begin
            if (RW_IDX[s] == a)
                r = {1'b1, 5'(s)};
        end
        return r;
    endfunction

    assign idx = i_wb_adr[9:2];
    assign req_go = i_wb_cyc && i_wb_stb && !ack_r;
    assign wr_go = req_go && i_wb_we && i_wb_sel[0];
    assign rd_go = req_go && !i_wb_we;
    assign o_wb_ack = ack_r;
    assign o_wb_dat = rdat_r;

    assign swap = nib_r[{5'd2, 1'b1}][SWAP_BIT-4];
    assign biased = fmt_r[FMT_BIASED_BIT];
    assign o_swap_mode = swap;
    assign o_fmt_biased = biased;
    assign o_fmt_ext = fmt_r[FMT_EXT_BIT];

    assign hi_view = view_to_phys(idx, 1'b1, swap);
    assign lo_view = view_to_phys(idx, 1'b0, swap);
    assign hi_look = slot_lookup(hi_view[8:1]);
    assign lo_look = slot_lookup(lo_view[8:1]);
    assign hi_nib = {hi_look[4:0], hi_view[0]};
    assign lo_nib = {lo_look[4:0], lo_view[0]};

    // One storage nibble per entry; bus writes go through the view map
    for (genvar j = 0; j < 2 * NUM_RW; j++)
    begin : g_nib
        always_ff @(posedge i_clk)
        begin
            if (i_rst)
                nib_r[j] <= (j % 2 == 1) ? RW_RESET[7:4] : RW_RESET[3:0];
            else if (wr_go && hi_look[5] && hi_nib == 6'(j))
                nib_r[j] <= i_wb_dat[7:4];
            else if (wr_go && lo_look[5] && lo_nib == 6'(j))
                nib_r[j] <= i_wb_dat[3:0];
        end
        assign o_settings[4*j+3:4*j] = nib_r[j];
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            fmt_r <= FMT_RESET;
        else if (wr_go && idx == IDX_FMT_CFG)
            fmt_r <= {6'h00, i_wb_dat[1:0]};
    end

    // Results are encoded by the same format bit, so limits written
    // in that form compare directly; software must keep them aligned.
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_enc
        trsf_enc_if u_if ();
        assign u_if.raw = ch_raw[c];
        assign u_if.fault = ch_fault[c];
        assign u_if.biased = biased;
        assign u_if.ext = fmt_r[FMT_EXT_BIT];
        assign code[c] = u_if.code;
        trsf_encoder u_enc (
            .e (u_if.enc)
        );
    end

    assign ch_raw[CH_LOCAL] = i_local_raw;
    assign ch_raw[CH_REM1] = i_rem1_raw;
    assign ch_fault[CH_LOCAL] = i_local_fault;
    assign ch_fault[CH_REM1] = i_rem1_fault;

    // Reading registers have no write path at all
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            local_r <= READ_RESET;
        else if (i_local_valid)
            local_r <= code[CH_LOCAL][9:2];
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            rem1_r <= READ_RESET;
        else if (i_rem1_valid)
            rem1_r <= code[CH_REM1][9:2];
    end

    // CPU data is relative and already in its own form: kept as is
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            cpu0_r <= READ_RESET;
        else if (i_cpu0_valid)
            cpu0_r <= i_cpu0_value;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            ext_r <= READ_RESET;
        else
        begin
            if (i_local_valid)
                ext_r[EXT_LOCAL_LSB+1:EXT_LOCAL_LSB] <=
                    code[CH_LOCAL][1:0];
            if (i_rem1_valid)
                ext_r[EXT_REM1_LSB+1:EXT_REM1_LSB] <=
                    code[CH_REM1][1:0];
        end
    end

    // Zone fields: only the remote-one code is redirected
    for (genvar p = 0; p < 3; p++)
    begin : g_zone
        logic [2:0] field;
        assign field = nib_r[{5'(8 + p), 1'b1}][3:1];
        assign o_pwm_zone_eff[3*p+2:3*p] =
            (swap && field == ZONE_REM1) ? ZONE_CPU0 : field;
    end

    always_comb
    begin
        rdat_nxt = 8'h00;
        if (idx == IDX_REM1_READ)
            rdat_nxt = swap ? cpu0_r : rem1_r;
        else if (idx == IDX_CPU0_READ)
            rdat_nxt = swap ? rem1_r : cpu0_r;
        else if (idx == IDX_LOCAL_READ)
            rdat_nxt = local_r;
        else if (idx == IDX_EXT_RES)
            rdat_nxt = ext_r;
        else if (idx == IDX_FMT_CFG)
            rdat_nxt = fmt_r;
        else if (hi_look[5])
            rdat_nxt = {nib_r[hi_nib], nib_r[lo_nib]};
    end

    // One wait state: the answer comes the cycle after the request
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            ack_r <= 1'b0;
        else
            ack_r <= req_go;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            rdat_r <= '0;
        else if (rd_go)
            rdat_r <= {24'h000000, rdat_nxt};
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_cfg_write(logic b);
        wr_go && idx == IDX_CPU_CFG && i_wb_dat[SWAP_BIT] == b;
    endsequence

    property p_swap_on;
        s_cfg_write(1'b1) |=> o_swap_mode;
    endproperty
    a_swap_on: assert property (p_swap_on)
        else $error("swap mode not entered after config write");

    property p_swap_off;
        s_cfg_write(1'b0) |=> !o_swap_mode;
    endproperty
    a_swap_off: assert property (p_swap_off)
        else $error("swap mode not left after config write");

    sequence s_read_rem1_slot;
        rd_go && idx == IDX_REM1_READ && swap && !i_cpu0_valid;
    endsequence

    property p_swap_read;
        s_read_rem1_slot |=> o_wb_ack && o_wb_dat[7:0] == cpu0_r;
    endproperty
    a_swap_read: assert property (p_swap_read)
        else $error("register 0x25 not showing cpu data in swap");

    property p_swap_low;
        (wr_go && swap && idx == IDX_REM1_LOW)
            |=> o_settings[7:0] == $past(i_wb_dat[7:0]);
    endproperty
    a_swap_low: assert property (p_swap_low)
        else $error("swapped low limit write missed cpu slot");

    property p_swap_hyst;
        (wr_go && swap && idx == IDX_HYST_A)
            |=> o_settings[16*8+3:16*8] == $past(i_wb_dat[7:4]);
    endproperty
    a_swap_hyst: assert property (p_swap_hyst)
        else $error("swapped hysteresis landed in wrong nibble");

    property p_zone;
        swap && nib_r[{5'd8, 1'b1}][3:1] == ZONE_REM1
            |-> o_pwm_zone_eff[2:0] == ZONE_CPU0;
    endproperty
    a_zone: assert property (p_zone)
        else $error("zone not redirected to cpu channel");

    property p_local_store;
        i_local_valid |=> local_r == $past(code[CH_LOCAL][9:2])
            && ext_r[3:2] == $past(code[CH_LOCAL][1:0]);
    endproperty
    a_local_store: assert property (p_local_store)
        else $error("local result not stored");

    property p_fault_twos;
        (i_local_valid && i_local_fault && !biased)
            |=> local_r == FAULT_TWOS;
    endproperty
    a_fault_twos: assert property (p_fault_twos)
        else $error("twos fault code wrong");

    property p_fault_bias;
        (i_local_valid && i_local_fault && biased)
            |=> local_r == FAULT_BIAS;
    endproperty
    a_fault_bias: assert property (p_fault_bias)
        else $error("biased fault code wrong");

    property p_range_twos;
        (i_local_valid && !i_local_fault && !biased)
            |=> $signed(local_r) >= 8'(TEMP_MIN_DEG);
    endproperty
    a_range_twos: assert property (p_range_twos)
        else $error("twos code below lowest temperature");

    property p_ro_read;
        (wr_go && idx == IDX_LOCAL_READ && !i_local_valid)
            |=> $stable(local_r);
    endproperty
    a_ro_read: assert property (p_ro_read)
        else $error("reading register changed by a write");
endmodule // trsf_regs

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import trsf_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_wb_cyc = 1'b0;
    logic i_wb_stb = 1'b0;
    logic i_wb_we = 1'b0;
    logic [ADR_W-1:0] i_wb_adr = '0;
    logic [3:0] i_wb_sel = 4'h0;
    logic [DAT_W-1:0] i_wb_dat = '0;
    logic [DAT_W-1:0] o_wb_dat;
    logic o_wb_ack;
    logic i_local_valid = 1'b0;
    logic signed [10:0] i_local_raw = '0;
    logic i_local_fault = 1'b0;
    logic i_rem1_valid = 1'b0;
    logic signed [10:0] i_rem1_raw = '0;
    logic i_rem1_fault = 1'b0;
    logic i_cpu0_valid = 1'b0;
    logic [7:0] i_cpu0_value = 8'h00;
    logic o_swap_mode;
    logic o_fmt_biased;
    logic o_fmt_ext;
    logic [8:0] o_pwm_zone_eff;
    logic [NUM_RW*8-1:0] o_settings;
    int fails = 0;
    int check_count = 0;
    logic [31:0] rdat;
    logic [7:0] pa [6] = '{8'h4e, 8'h4f, 8'h67, 8'h6a, 8'h70, 8'h8b};
    logic [7:0] pb [6] = '{8'h34, 8'h35, 8'h3b, 8'h3d, 8'h94, 8'h8a};

    always #25 i_clk = ~i_clk;

    trsf_regs uut (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc),
        .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
        .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
        .o_wb_ack(o_wb_ack), .i_local_valid(i_local_valid),
        .i_local_raw(i_local_raw), .i_local_fault(i_local_fault),
        .i_rem1_valid(i_rem1_valid), .i_rem1_raw(i_rem1_raw),
        .i_rem1_fault(i_rem1_fault), .i_cpu0_valid(i_cpu0_valid),
        .i_cpu0_value(i_cpu0_value), .o_swap_mode(o_swap_mode),
        .o_fmt_biased(o_fmt_biased), .o_fmt_ext(o_fmt_ext),
        .o_pwm_zone_eff(o_pwm_zone_eff), .o_settings(o_settings));

    task automatic give_verdict();
        $display("Checks made %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
        input string what);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h",
                $time, what, seen, exp);
        end
    endtask

    // One classic cycle; request held until ack is sampled high
    task automatic bus(input logic we, input logic [7:0] idx,
        input logic [7:0] wd);
        int n;
        @(posedge i_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= we;
        i_wb_adr <= {idx, 2'b00};
        i_wb_dat <= {24'h0, wd};
        i_wb_sel <= 4'hf;
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 20);
        rdat = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        i_wb_we <= 1'b0;
        if (o_wb_ack !== 1'b1)
        begin
            fails++;
            $display("CHECK FAILED at %0t: no bus answer", $time);
            give_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        bus(1'b1, idx, wd);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check(rdat, {24'h0, exp}, $sformatf("read of index %h", idx));
    endtask

    // ch 0 local, 1 remote one, 2 cpu channel
    task automatic meas(input int ch, input logic signed [10:0] raw,
        input logic flt);
        @(posedge i_clk);
        i_local_valid <= (ch == 0);
        i_rem1_valid <= (ch == 1);
        i_cpu0_valid <= (ch == 2);
        i_local_raw <= raw;
        i_rem1_raw <= raw;
        i_local_fault <= flt;
        i_rem1_fault <= flt;
        i_cpu0_value <= raw[7:0];
        @(posedge i_clk);
        i_local_valid <= 1'b0;
        i_rem1_valid <= 1'b0;
        i_cpu0_valid <= 1'b0;
    endtask

    task automatic t_access();
        check({31'h0, o_swap_mode}, 32'h0, "swap after reset");
        check(o_settings[31:0], 32'h0, "settings after reset");
        wr(8'h26, 8'h5a);
        rd(8'h26, 8'h00);
        wr(8'h77, 8'hff);
        rd(8'h77, 8'h00);
        wr(8'h10, 8'haa);
        rd(8'h10, 8'h00);
        $display("test access done");
    endtask

    task automatic t_twos();
        meas(0, 11'sd102, 1'b0);
        rd(8'h26, 8'h19);
        rd(8'h77, 8'h08);
        meas(0, 11'sd203, 1'b0);
        rd(8'h26, 8'h32);
        rd(8'h77, 8'h0c);
        meas(0, -11'sd40, 1'b0);
        rd(8'h26, 8'hf6);
        meas(0, -11'sd300, 1'b0);
        rd(8'h26, 8'hc1);
        meas(0, 11'sd0, 1'b1);
        rd(8'h26, FAULT_TWOS);
        rd(8'h77, 8'h00);
        $display("test twos complement done");
    endtask

    task automatic t_biased();
        wr(IDX_FMT_CFG, 8'h01);
        check({31'h0, o_fmt_biased}, 32'h1, "biased flag");
        meas(0, 11'sd0, 1'b0);
        rd(8'h26, 8'h40);
        meas(0, -11'sd4, 1'b0);
        rd(8'h26, 8'h3f);
        meas(0, 11'sd600, 1'b0);
        rd(8'h26, 8'hbf);
        meas(0, 11'sd0, 1'b1);
        rd(8'h26, FAULT_BIAS);
        wr(IDX_FMT_CFG, 8'h03);
        check({31'h0, o_fmt_ext}, 32'h1, "extended flag");
        rd(IDX_FMT_CFG, 8'h03);
        meas(0, 11'sd764, 1'b0);
        rd(8'h26, 8'hff);
        meas(0, 11'sd900, 1'b0);
        rd(8'h26, 8'hff);
        wr(IDX_FMT_CFG, 8'h00);
        $display("test biased done");
    endtask

    task automatic t_swap();
        meas(1, 11'sd161, 1'b0);
        meas(2, 11'sh0a5, 1'b0);
        rd(8'h25, 8'h28);
        rd(8'h33, 8'ha5);
        rd(8'h77, 8'h0d);
        for (int i = 0; i < 6; i++)
        begin
            wr(pa[i], 8'h10 + 8'(i));
            wr(pb[i], 8'h80 + 8'(i));
        end
        wr(8'h5f, 8'h9c);
        wr(8'h3c, 8'h5e);
        wr(8'h62, 8'h0b);
        wr(8'h6d, 8'h12);
        wr(8'h6e, 8'h34);
        wr(IDX_CPU_CFG, 8'h10);
        check({31'h0, o_swap_mode}, 32'h1, "swap entered");
        rd(8'h25, 8'ha5);
        rd(8'h33, 8'h28);
        for (int i = 0; i < 6; i++)
        begin
            rd(pa[i], 8'h80 + 8'(i));
            rd(pb[i], 8'h10 + 8'(i));
        end
        rd(8'h5f, 8'h5c);
        rd(8'h3c, 8'h9b);
        rd(8'h62, 8'h0e);
        rd(8'h6d, 8'h43);
        rd(8'h6e, 8'h21);
        wr(8'h4e, 8'h77);
        check(o_settings[7:0], 32'h77, "swapped write slot");
        $display("test swap done");
    endtask

    task automatic t_zone();
        wr(8'h5c, 8'h00);
        wr(8'h5d, 8'h20);
        wr(8'h5e, 8'he0);
        check(o_pwm_zone_eff, {3'h7, 3'h1, ZONE_CPU0}, "zones swapped");
        wr(IDX_CPU_CFG, 8'h00);
        check({31'h0, o_swap_mode}, 32'h0, "swap left");
        check(o_pwm_zone_eff, {3'h7, 3'h1, ZONE_REM1}, "zones plain");
        rd(8'h25, 8'h28);
        rd(8'h4e, 8'h10);
        rd(8'h34, 8'h77);
        $display("test zone done");
    endtask

    initial
    begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        t_access();
        t_twos();
        t_biased();
        t_swap();
        t_zone();
        give_verdict();
    end
endmodule // testbench
